// ### hdl/spi_link_pkg.sv
package spi_link_pkg;
  // byte framing on the wire
  localparam int BYTE_W = 8;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] FIRST_BIT = 3'h0;
  localparam logic [CNT_W-1:0] LAST_BIT = 3'h7;
  localparam logic [BYTE_W-1:0] FILL_BYTE = 8'h00; // sent when nothing is queued

  // serial clock limits, 5 Mb/s at most
  localparam int REF_PERIOD_NS = 4;
  localparam int SCLK_MIN_PERIOD_NS = 200;
  // half period in ref_clk cycles, rounded up so the rate never exceeds the limit
  localparam int SCLK_HALF_CYC =
    (SCLK_MIN_PERIOD_NS + 2 * REF_PERIOD_NS - 1) / (2 * REF_PERIOD_NS);
  // synchroniser depth; a half period must outlast it
  localparam int SYNC_LAT = 2;

  // host register map, word aligned
  localparam int OFS_W = 8;
  localparam logic [OFS_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [OFS_W-1:0] TXDATA_OFS = 8'h04;
  localparam logic [OFS_W-1:0] RXDATA_OFS = 8'h08;
  localparam logic [OFS_W-1:0] STATUS_OFS = 8'h0c;
  localparam int CTRL_SEL_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ALERT_BIT = 1;
  localparam int ST_DONE_BIT = 2;
  localparam logic CTRL_RESET = 1'b0;

  // bus encodings
  localparam int HTRANS_ACT_BIT = 1; // set for NONSEQ and SEQ
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // host transfer sequencer
  typedef enum logic [1:0] {
    XFER_IDLE = 2'b00,
    XFER_LOW = 2'b01,
    XFER_HIGH = 2'b10
  } xfer_state_t;
endpackage

// ### hdl/spi_link_if.sv
`timescale 1ns/100ps
interface spi_link_if;
  logic sclk; // serial clock, made by the host
  logic mosi; // host to port data
  logic miso; // port to host data
  logic port_select_line_n; // port select, active low
  logic host_alert_line_n; // port has data queued, active low

  modport device (
    input sclk,
    input mosi,
    input port_select_line_n,
    output miso,
    output host_alert_line_n
  );
  modport host (
    output sclk,
    output mosi,
    output port_select_line_n,
    input miso,
    input host_alert_line_n
  );
endinterface

// ### hdl/spi_slave_port.sv
// Summary of operation
// - port is slave only, clock from master
// - shift outgoing bits at serial clock rate
// - system tri-states miso when deselected; the port keeps miso driven
// - master selects first, mosi is input
// - master makes clock, at most 5 Mb/s
// - low select enables serial communication
// - alert low while queued, always driven; the port lowers it only with port_enable set
// - alert held until queued byte clocked out
// - most significant bit first on wire
// - mode zero: idle low, sample rising
// - unescaped framing only, mode setting ignored
// - full duplex, filler bytes both ways
// - valid data may overlap both ways
// - pull-ups on by default, can disable
// - inactive until first select, then sticky; a select wakes the port only with port_enable set
// - overflowing received bytes are discarded
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/100ps
module spi_slave_port
  import spi_link_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  spi_link_if.device link,
  input wire logic port_enable,
  input wire logic pullup_disable,
  output logic pullup_config,
  input wire logic [BYTE_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [BYTE_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_drop,
  output logic port_active
);

  // ---------------- ref_clk domain ----------------
  logic link_clr_reg; // registered reset, clears the link side
  logic ss_meta_reg; // select synchroniser
  logic ss_sync_reg;
  logic active_reg; // port in use since first select with port_enable set
  logic pullup_reg; // 1 = input pull-ups enabled
  logic [BYTE_W-1:0] tx_hold_reg; // byte offered to the link
  logic tx_req_reg; // toggles once per offered byte
  logic ack_meta_reg; // ack synchroniser
  logic ack_sync_reg;
  logic tx_pending; // offered byte not yet clocked out
  logic alert_reg; // alert pin, active low
  logic rxt_meta_reg; // receive toggle synchroniser
  logic rxt_sync_reg;
  logic rxt_seen_reg; // last toggle value acted on
  logic rx_edge; // a new byte stands in rx_hold_reg
  logic [BYTE_W-1:0] rx_data_reg;
  logic rx_valid_reg;
  logic rx_drop_reg;

  // ---------------- link domain ----------------
  logic sel_clr; // async clear while deselected
  logic [CNT_W-1:0] bit_cnt_reg; // bit within current byte
  logic [BYTE_W-1:0] rx_sr_reg; // incoming shift register
  logic [BYTE_W-1:0] rx_hold_reg; // completed byte, stable for a byte time
  logic rx_tgl_reg; // toggles per completed byte
  logic req_meta_reg; // offer synchroniser
  logic req_sync_reg;
  logic ack_tgl_reg; // toggles when a real byte is clocked out
  logic real_reg; // byte on the wire is queued data
  logic [BYTE_W-1:0] tx_sr_reg; // outgoing shift register
  logic have_new; // an offered byte waits
  logic [BYTE_W-1:0] next_byte; // byte to start with at bit zero

  // reset into a flop so the link side sees a clean async clear
  always_ff @(posedge ref_clk) begin
    link_clr_reg <= reset;
  end

  // select pin crosses into ref_clk
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ss_meta_reg <= 1'b1;
      ss_sync_reg <= 1'b1;
    end else begin
      ss_meta_reg <= link.port_select_line_n;
      ss_sync_reg <= ss_meta_reg;
    end
  end

  // port wakes on first select with port_enable set and stays in use until reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      active_reg <= 1'b0;
    end else if (port_enable && !ss_sync_reg) begin
      active_reg <= 1'b1;
    end
  end
  assign port_active = active_reg;

  // pull-ups come up enabled, software may switch them off
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pullup_reg <= 1'b1;
    end else begin
      pullup_reg <= ~pullup_disable;
    end
  end
  assign pullup_config = pullup_reg;

  // ack toggle crosses back from the link
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
    end else begin
      ack_meta_reg <= ack_tgl_reg;
      ack_sync_reg <= ack_meta_reg;
    end
  end

  assign tx_pending = (tx_req_reg != ack_sync_reg);
  assign tx_ready = ~tx_pending;

  // one byte is offered at a time; it stays put until acked
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_hold_reg <= FILL_BYTE;
      tx_req_reg <= 1'b0;
    end else if (tx_valid && !tx_pending) begin
      tx_hold_reg <= tx_data;
      tx_req_reg <= ~tx_req_reg;
    end
  end

  // alert pin is always driven; high when the port is not configured
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      alert_reg <= 1'b1;
    end else begin
      alert_reg <= ~(port_enable && tx_pending);
    end
  end
  assign link.host_alert_line_n = alert_reg;

  // receive toggle crosses into ref_clk
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rxt_meta_reg <= 1'b0;
      rxt_sync_reg <= 1'b0;
      rxt_seen_reg <= 1'b0;
    end else begin
      rxt_meta_reg <= rx_tgl_reg;
      rxt_sync_reg <= rxt_meta_reg;
      rxt_seen_reg <= rxt_sync_reg;
    end
  end
  assign rx_edge = (rxt_sync_reg != rxt_seen_reg) && active_reg;

  // single receive slot; a byte finding it still full is thrown away
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_valid_reg <= 1'b0;
      rx_data_reg <= FILL_BYTE;
    end else if (rx_edge && !(rx_valid_reg && !rx_ready)) begin
      rx_valid_reg <= 1'b1; // new byte wins over a same-cycle take
      rx_data_reg <= rx_hold_reg; // bytes pass raw, framing is upstream
    end else if (rx_ready) begin
      rx_valid_reg <= 1'b0;
    end
  end
  assign rx_valid = rx_valid_reg;
  assign rx_data = rx_data_reg;

  // drop pulse, no flow control toward the master
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_drop_reg <= 1'b0;
    end else begin
      rx_drop_reg <= rx_edge && rx_valid_reg && !rx_ready;
    end
  end
  assign rx_drop = rx_drop_reg;

  // ---------------- link logic, clocked by the master's clock ----------------
  assign sel_clr = link.port_select_line_n | link_clr_reg;

  // bit counter held at zero while deselected
  always_ff @(posedge link.sclk or posedge sel_clr) begin
    if (sel_clr) begin
      bit_cnt_reg <= FIRST_BIT;
    end else begin
      bit_cnt_reg <= CNT_W'(bit_cnt_reg + 1'b1);
    end
  end

  // incoming bits sampled on rising edges, first bit is the msb
  always_ff @(posedge link.sclk or posedge link_clr_reg) begin
    if (link_clr_reg) begin
      rx_sr_reg <= FILL_BYTE;
      rx_hold_reg <= FILL_BYTE;
      rx_tgl_reg <= 1'b0;
    end else if (!link.port_select_line_n) begin
      rx_sr_reg <= {rx_sr_reg[BYTE_W-2:0], link.mosi};
      if (bit_cnt_reg == LAST_BIT) begin
        rx_hold_reg <= {rx_sr_reg[BYTE_W-2:0], link.mosi};
        rx_tgl_reg <= ~rx_tgl_reg;
      end
    end
  end

  // offer toggle crosses into the link; only advances while clocked
  always_ff @(posedge link.sclk or posedge link_clr_reg) begin
    if (link_clr_reg) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
    end else begin
      req_meta_reg <= tx_req_reg;
      req_sync_reg <= req_meta_reg;
    end
  end

  assign have_new = (req_sync_reg != ack_tgl_reg);
  // filler goes out when nothing waits, so every byte in is matched by one out
  assign next_byte = have_new ? tx_hold_reg : FILL_BYTE;

  // outgoing byte loaded at bit zero, acked after its last bit
  always_ff @(posedge link.sclk or posedge link_clr_reg) begin
    if (link_clr_reg) begin
      tx_sr_reg <= FILL_BYTE;
      real_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
    end else if (!link.port_select_line_n) begin
      if (bit_cnt_reg == FIRST_BIT) begin
        tx_sr_reg <= {next_byte[BYTE_W-2:0], 1'b0};
        real_reg <= have_new;
      end else begin
        tx_sr_reg <= {tx_sr_reg[BYTE_W-2:0], 1'b0};
      end
      if (bit_cnt_reg == LAST_BIT && real_reg) begin
        ack_tgl_reg <= ~ack_tgl_reg;
      end
    end
  end

  // msb must stand before the first rising edge; miso stays driven,
  // isolation on a shared bus is left to the board
  assign link.miso = (bit_cnt_reg == FIRST_BIT) ? next_byte[BYTE_W-1]
                                                : tx_sr_reg[BYTE_W-1];
endmodule // spi_slave_port

// ### hdl/spi_host_master.sv
`timescale 1ns/100ps
module spi_host_master
  import spi_link_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC // ref_clk cycles per clock half
)(
  input wire logic ref_clk,
  input wire logic reset,
  spi_link_if.host link,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);
  localparam int HC_W = $clog2(HALF_CYC + 1);

  // a half period must cover the miso synchroniser, and the rate limit
  if (HALF_CYC < SYNC_LAT + 1 || HALF_CYC < SCLK_HALF_CYC) begin : g_bad_half
    $error("HALF_CYC too small for sync latency or clock rate limit");
  end

  xfer_state_t state_reg; // sequencer state
  logic [HC_W-1:0] half_cnt_reg; // cycles left in this half
  logic [CNT_W-1:0] bit_cnt_reg; // bit within byte
  logic [BYTE_W-1:0] tx_sr_reg; // outgoing shift register
  logic [BYTE_W-1:0] rx_sr_reg; // incoming shift register
  logic [BYTE_W-1:0] rx_byte_reg; // last full byte received
  logic sclk_reg;
  logic mosi_reg;
  logic sel_reg; // select held by software
  logic done_reg; // sticky byte-finished flag
  logic miso_meta_reg; // input synchronisers
  logic miso_sync_reg;
  logic alert_meta_reg;
  logic alert_sync_reg;
  logic wr_pend_reg; // write data phase pending
  logic [OFS_W-1:0] wr_ofs_reg;
  logic [31:0] hrdata_reg;
  logic addr_ok; // valid address phase this cycle
  logic start; // accepted transmit write
  logic half_end; // last cycle of a clock half
  logic finish; // last cycle of the high half of the last bit

  // read view of the register map
  function automatic logic [31:0] reg_read(input logic [OFS_W-1:0] ofs);
    logic [31:0] v;
    v = RD_ZERO;
    case (ofs)
      CTRL_OFS: v[CTRL_SEL_BIT] = sel_reg;
      RXDATA_OFS: v[BYTE_W-1:0] = rx_byte_reg;
      STATUS_OFS: begin
        v[ST_BUSY_BIT] = (state_reg != XFER_IDLE);
        v[ST_ALERT_BIT] = ~alert_sync_reg;
        v[ST_DONE_BIT] = done_reg;
      end
      default: v = RD_ZERO; // unmapped and write-only read zero
    endcase
    return v;
  endfunction

  // miso and alert come from the other domain
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      miso_meta_reg <= 1'b0;
      miso_sync_reg <= 1'b0;
      alert_meta_reg <= 1'b1;
      alert_sync_reg <= 1'b1;
    end else begin
      miso_meta_reg <= link.miso;
      miso_sync_reg <= miso_meta_reg;
      alert_meta_reg <= link.host_alert_line_n;
      alert_sync_reg <= alert_meta_reg;
    end
  end

  // bus slave: zero wait states, read data registered in the address phase
  assign addr_ok = hsel && htrans[HTRANS_ACT_BIT] && hready;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg <= CTRL_OFS;
      hrdata_reg <= RD_ZERO;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_ofs_reg <= haddr[OFS_W-1:0];
      hrdata_reg <= (addr_ok && !hwrite) ? reg_read(haddr[OFS_W-1:0]) : RD_ZERO;
    end
  end
  assign hreadyout = 1'b1;
  assign hrdata = hrdata_reg;
  assign hresp = HRESP_OKAY;

  // software drives select; data only moves once selected
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sel_reg <= CTRL_RESET;
    end else if (wr_pend_reg && wr_ofs_reg == CTRL_OFS) begin
      sel_reg <= hwdata[CTRL_SEL_BIT];
    end
  end
  assign link.port_select_line_n = ~sel_reg;

  // a byte write while busy or deselected is ignored
  assign start = wr_pend_reg && wr_ofs_reg == TXDATA_OFS && sel_reg
                 && state_reg == XFER_IDLE;
  assign half_end = (half_cnt_reg == '0);
  assign finish = state_reg == XFER_HIGH && half_end && bit_cnt_reg == LAST_BIT;

  // sequencer: low half then high half for each bit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= XFER_IDLE;
      half_cnt_reg <= '0;
      bit_cnt_reg <= FIRST_BIT;
    end else begin
      case (state_reg)
        XFER_IDLE: begin
          if (start) begin
            state_reg <= XFER_LOW;
            half_cnt_reg <= HC_W'(HALF_CYC - 1);
            bit_cnt_reg <= FIRST_BIT;
          end
        end
        XFER_LOW: begin
          if (half_end) begin
            state_reg <= XFER_HIGH;
            half_cnt_reg <= HC_W'(HALF_CYC - 1);
          end else begin
            half_cnt_reg <= HC_W'(half_cnt_reg - 1'b1);
          end
        end
        XFER_HIGH: begin
          if (finish) begin
            state_reg <= XFER_IDLE;
          end else if (half_end) begin
            state_reg <= XFER_LOW;
            half_cnt_reg <= HC_W'(HALF_CYC - 1);
            bit_cnt_reg <= CNT_W'(bit_cnt_reg + 1'b1);
          end else begin
            half_cnt_reg <= HC_W'(half_cnt_reg - 1'b1);
          end
        end
        default: state_reg <= XFER_IDLE;
      endcase
    end
  end

  // clock idles low and rises to start the high half
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sclk_reg <= 1'b0;
    end else if (state_reg == XFER_LOW && half_end) begin
      sclk_reg <= 1'b1;
    end else if (state_reg == XFER_HIGH && half_end) begin
      sclk_reg <= 1'b0;
    end
  end
  assign link.sclk = sclk_reg;

  // outgoing bits, msb first, changed only while the clock is low
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_sr_reg <= FILL_BYTE;
      mosi_reg <= 1'b0;
    end else if (start) begin
      tx_sr_reg <= hwdata[BYTE_W-1:0];
      mosi_reg <= hwdata[BYTE_W-1];
    end else if (state_reg == XFER_HIGH && half_end && !finish) begin
      tx_sr_reg <= {tx_sr_reg[BYTE_W-2:0], 1'b0};
      mosi_reg <= tx_sr_reg[BYTE_W-2];
    end
  end
  assign link.mosi = mosi_reg;

  // incoming bits taken as the clock rises; every byte sent returns one
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_sr_reg <= FILL_BYTE;
      rx_byte_reg <= FILL_BYTE;
    end else begin
      if (state_reg == XFER_LOW && half_end) begin
        rx_sr_reg <= {rx_sr_reg[BYTE_W-2:0], miso_sync_reg};
      end
      if (finish) begin
        rx_byte_reg <= rx_sr_reg;
      end
    end
  end

  // done flag: write one to clear, a finishing byte wins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      done_reg <= 1'b0;
    end else if (finish) begin
      done_reg <= 1'b1;
    end else if (wr_pend_reg && wr_ofs_reg == STATUS_OFS && hwdata[ST_DONE_BIT]) begin
      done_reg <= 1'b0;
    end
  end
endmodule // spi_host_master

// ### tb/spi_link_asserts.sv
`timescale 1ns/100ps
module spi_link_asserts #(
  parameter int HALF_CYC = 25 // ref_clk cycles per serial clock half
)(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic port_select_line_n,
  input wire logic host_alert_line_n
);
  default clocking main_cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  logic sclk_q; // clock level one sample ago
  logic [11:0] hold_cnt; // samples the level has held
  logic [3:0] alert_rises; // rises while alert low
  logic [2:0] sel_rises; // rises in this select, mod 8

  // saturating hold count, so a long idle never wraps to a short one
  always_ff @(posedge ref_clk) begin
    sclk_q <= sclk;
    if (reset || sclk != sclk_q) begin
      hold_cnt <= 12'h000;
    end else if (hold_cnt != 12'hfff) begin
      hold_cnt <= hold_cnt + 12'h001;
    end
  end

  // rises seen while the alert is low
  always_ff @(posedge ref_clk) begin
    if (reset || host_alert_line_n) begin
      alert_rises <= 4'h0;
    end else if (sclk && !sclk_q && alert_rises != 4'hf) begin
      alert_rises <= alert_rises + 4'h1;
    end
  end

  // rises within one select window
  always_ff @(posedge ref_clk) begin
    if (reset || port_select_line_n) begin
      sel_rises <= 3'h0;
    end else if (sclk && !sclk_q) begin
      sel_rises <= sel_rises + 3'h1;
    end
  end

  sclk_idle_low_a: assert property (sclk |-> !port_select_line_n)
    else $error("serial clock high while deselected");
  sclk_rate_a: assert property ($changed(sclk) |-> hold_cnt >= HALF_CYC - 1)
    else $error("serial clock half period too short");
  sclk_high_time_a: assert property ($rose(sclk) |-> ##HALF_CYC $fell(sclk))
    else $error("serial clock high time wrong");
  select_lead_a: assert property ($fell(port_select_line_n) |-> !sclk [*8])
    else $error("clock edge too soon after select");
  mosi_setup_a: assert property (sclk |-> $stable(mosi))
    else $error("mosi moved while clock high");
  miso_hold_a: assert property (
    !port_select_line_n && !$past(port_select_line_n, 4) && !$rose(sclk) |-> $stable(miso))
    else $error("miso moved away from a rising edge");
  alert_hold_a: assert property ($rose(host_alert_line_n) |-> alert_rises >= 4'h8)
    else $error("alert released before a byte went out");
  whole_bytes_a: assert property ($rose(port_select_line_n) |-> sel_rises == 3'h0)
    else $error("select ended inside a byte");

  duplex_c: cover property (!port_select_line_n && $rose(sclk) && mosi && miso);
  alert_c: cover property ($fell(host_alert_line_n));
  select_c: cover property ($rose(port_select_line_n));
endmodule // spi_link_asserts

// ### tb/spi_slave_host_port_test.sv
`timescale 1ns/100ps
`define CHK(nm, e, s) begin \
  comparisons++; \
  if ((s) !== (e)) begin \
    mismatches++; \
    $display("BAD %s expected %0h seen %0h", nm, e, s); \
  end \
end
module spi_slave_host_port_test
  import spi_link_pkg::*;
;
  logic ref_clk = 1'h0; // system clock
  logic reset = 1'h1; // sync reset
  logic port_enable = 1'h0; // port configured
  logic pullup_disable = 1'h0; // pull-up switch
  logic [BYTE_W-1:0] tx_data = FILL_BYTE; // byte offered by device user
  logic tx_valid = 1'h0; // offer strobe
  logic rx_ready = 1'h0; // device user takes byte
  logic pullup_config, tx_ready, rx_valid, rx_drop, port_active; // device status
  logic [BYTE_W-1:0] rx_data; // byte received by device
  logic hsel = 1'h0; // bus select
  logic hwrite = 1'h0; // bus direction
  logic [1:0] htrans = 2'h0; // idle until a transfer
  logic [2:0] hsize = 3'h2; // always a word
  logic [31:0] haddr = 32'h0000_0000; // address phase
  logic [31:0] hwdata = 32'h0000_0000; // data phase
  logic hreadyout, hresp; // slave answer
  logic [31:0] hrdata; // read data
  logic [BYTE_W-1:0] mon_mosi, mon_miso; // bytes seen on the wire
  int mismatches = 0; // failed comparisons
  int comparisons = 0; // comparisons made
  int drops = 0; // discard pulses seen

  // lone slave on this bus, so miso needs no isolation
  spi_link_if spi_link_if_inst ();
  spi_slave_port spi_slave_port_inst (.ref_clk(ref_clk), .reset(reset),
    .link(spi_link_if_inst.device), .port_enable(port_enable),
    .pullup_disable(pullup_disable), .pullup_config(pullup_config), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_drop(rx_drop), .port_active(port_active));
  spi_host_master #(.HALF_CYC(SCLK_HALF_CYC)) spi_host_master_inst (.ref_clk(ref_clk),
    .reset(reset), .link(spi_link_if_inst.host), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
  spi_link_asserts #(.HALF_CYC(SCLK_HALF_CYC)) spi_link_asserts_inst (.ref_clk(ref_clk),
    .reset(reset), .sclk(spi_link_if_inst.sclk), .mosi(spi_link_if_inst.mosi),
    .miso(spi_link_if_inst.miso), .port_select_line_n(spi_link_if_inst.port_select_line_n),
    .host_alert_line_n(spi_link_if_inst.host_alert_line_n));

  // 250 MHz
  always #2 ref_clk = ~ref_clk;

  // wire monitor, shifts at the sampling edge so msb lands on top
  always @(posedge spi_link_if_inst.sclk) begin
    if (!spi_link_if_inst.port_select_line_n) begin
      mon_mosi <= {mon_mosi[6:0], spi_link_if_inst.mosi};
      mon_miso <= {mon_miso[6:0], spi_link_if_inst.miso};
    end
  end

  // discard pulses last one cycle, so count them as they pass
  always @(posedge ref_clk) begin
    if (rx_drop === 1'h1) begin
      drops++;
    end
  end

  // filler while the offer crosses, then the offered byte
  function automatic logic [7:0] host_expect(input logic [7:0] dev, input int slot);
    return (slot == 0) ? FILL_BYTE : dev;
  endfunction

  // status word from its flags
  function automatic logic [31:0] status_exp(input logic busy, input logic alert);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ST_BUSY_BIT] = busy;
    w[ST_ALERT_BIT] = alert;
    return w;
  endfunction

  // single word transfer; address phase held until hready, then data phase
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'h1;
    haddr <= {24'h00_0000, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  task automatic set_sel(input logic s);
    logic [31:0] rd;
    bus(1'h1, CTRL_OFS, 32'(s), rd);
  endtask

  // one host byte out, one byte back; polls done, then clears it
  task automatic xfer(input logic [7:0] hb, output logic [7:0] got);
    logic [31:0] rd;
    bus(1'h1, TXDATA_OFS, {24'h00_0000, hb}, rd);
    rd = 32'h0000_0000;
    while (rd[ST_DONE_BIT] !== 1'h1) begin
      bus(1'h0, STATUS_OFS, 32'h0000_0000, rd);
    end
    `CHK("busy", 1'h0, rd[ST_BUSY_BIT])
    bus(1'h0, RXDATA_OFS, 32'h0000_0000, rd);
    got = rd[7:0];
    `CHK("mosi byte", hb, mon_mosi)
    `CHK("miso byte", mon_miso, got)
    bus(1'h1, STATUS_OFS, 32'h0000_0001 << ST_DONE_BIT, rd);
  endtask

  // device user offers a byte and holds it until taken
  task automatic offer(input logic [7:0] b);
    @(posedge ref_clk);
    tx_data <= b;
    tx_valid <= 1'h1;
    do @(posedge ref_clk); while (tx_ready !== 1'h1);
    tx_valid <= 1'h0;
  endtask

  // device user checks and takes the received byte
  task automatic take(input logic [7:0] e);
    `CHK("rx_valid", 1'h1, rx_valid)
    `CHK("rx_data", e, rx_data)
    @(posedge ref_clk);
    rx_ready <= 1'h1;
    @(posedge ref_clk);
    rx_ready <= 1'h0;
  endtask

  task automatic end_test(input string nm);
    $display("test %s done, %0d mismatches so far", nm, mismatches);
  endtask

  task automatic close_out();
    $display("%0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    logic [31:0] rd;
    logic [7:0] a, d, got;
    void'($urandom(32'hb246_783d));
    repeat (4) @(posedge ref_clk);
    reset <= 1'h0;
    `CHK("pullup_config", 1'h1, pullup_config)
    `CHK("alert", 1'h1, spi_link_if_inst.host_alert_line_n)
    `CHK("port_active", 1'h0, port_active)
    `CHK("sclk", 1'h0, spi_link_if_inst.sclk)
    end_test("reset");
    @(posedge ref_clk);
    pullup_disable <= 1'h1;
    repeat (3) @(posedge ref_clk);
    `CHK("pullup_config", 1'h0, pullup_config)
    pullup_disable <= 1'h0;
    repeat (3) @(posedge ref_clk);
    `CHK("pullup_config", 1'h1, pullup_config)
    end_test("pullup");
    // corner cases: byte while deselected, unmapped place, disabled port
    bus(1'h1, TXDATA_OFS, 32'h0000_00a5, rd);
    bus(1'h0, STATUS_OFS, 32'h0000_0000, rd);
    `CHK("status", status_exp(1'h0, 1'h0), rd)
    bus(1'h0, 8'h10, 32'h0000_0000, rd);
    `CHK("unmapped", 32'h0000_0000, rd)
    set_sel(1'h1);
    bus(1'h0, CTRL_OFS, 32'h0000_0000, rd);
    `CHK("ctrl", 32'h0000_0001 << CTRL_SEL_BIT, rd)
    xfer(8'($urandom), got);
    `CHK("rx_valid", 1'h0, rx_valid)
    `CHK("port_active", 1'h0, port_active)
    set_sel(1'h0);
    // let the high select cross first, or its stale low level wakes the port
    repeat (4) @(posedge ref_clk);
    port_enable <= 1'h1;
    repeat (4) @(posedge ref_clk);
    `CHK("port_active", 1'h0, port_active)
    for (int k = 0; k < 3; k++) begin
      set_sel(k[0] == 1'h0);
      repeat (4) @(posedge ref_clk);
      `CHK("port_active", 1'h1, port_active)
    end
    end_test("activation");
    // random bytes both ways at once
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      offer(d);
      repeat (2) @(posedge ref_clk);
      `CHK("alert", 1'h0, spi_link_if_inst.host_alert_line_n)
      bus(1'h0, STATUS_OFS, 32'h0000_0000, rd);
      `CHK("status", status_exp(1'h0, 1'h1), rd)
      for (int s = 0; s < 2; s++) begin
        a = 8'($urandom);
        xfer(a, got);
        `CHK("host rx", host_expect(d, s), got)
        take(a);
        if (s == 0) begin
          `CHK("alert", 1'h0, spi_link_if_inst.host_alert_line_n)
        end
      end
      `CHK("alert", 1'h1, spi_link_if_inst.host_alert_line_n)
      `CHK("tx_ready", 1'h1, tx_ready)
    end
    end_test("duplex");
    // second byte arrives while the slot is still full
    a = 8'($urandom);
    d = ~a;
    xfer(a, got);
    xfer(d, got);
    `CHK("filler", FILL_BYTE, got)
    `CHK("drops", 1, drops)
    take(a);
    @(posedge ref_clk);
    `CHK("rx_valid", 1'h0, rx_valid)
    end_test("overflow");
    close_out();
  end

  // about a dozen byte exchanges of some 450 cycles each, with wide margin
  initial begin
    repeat (40000) @(posedge ref_clk);
    $display("watchdog expired");
    mismatches++;
    close_out();
  end
endmodule // spi_slave_host_port_test
